// File: verilog/gcs_top.sv
// gcs_top: gain control loop and carrier sense detector with APB registers
`default_nettype none

module gcs_top
    import gcs_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [7:0] sample_amp,
    input wire logic sync_found,
    input wire logic rx_restart,
    output logic [2:0] lna1_gain,
    output logic [2:0] lna2_gain,
    output logic [1:0] dvga_gain,
    output logic carrier_sense,
    output logic ook_bit,
    output logic [7:0] rssi_db,
    output logic irq
);

    // ======================================================================
    // state
    typedef struct packed {
        logic [7:0] prio_thr;
        logic [7:0] loop_cfg;
        logic [2:0] target;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        logic [2:0] lna1;
        logic [2:0] lna2;
        logic [1:0] dvga;
        gcs_loop_t loop;
        logic [5:0] settle_cnt;
        logic sync_hold;
        logic [7:0] rssi;
        logic [7:0] rel_base;
        logic rel_hit;
        logic abs_hit;
        logic cs;
        logic ook;
        logic irq;
        logic avg_clear;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } gcs_top_state_t;

    gcs_top_state_t s_reg;
    gcs_top_state_t s_next;

    // ======================================================================
    // helpers
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [7:0] idx);
        hit = (a == AW'({idx, 2'b00}));
    endfunction : hit

    function automatic logic [7:0] gain_loss(input logic [2:0] l1,
                                             input logic [2:0] l2,
                                             input logic [1:0] dv);
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] d3;
        d1 = {5'h00, 3'(LNA_MAX - l1)};
        d2 = {5'h00, 3'(LNA_MAX - l2)};
        d3 = {6'h00, 2'(DVGA_MAX - dv)};
        gain_loss = 8'(d1 * LNA_STEP_DB + d2 * LNA_STEP_DB
                       + d3 * DVGA_STEP_DB);
    endfunction : gain_loss

    gcs_avg_if avg_bus();

    gcs_avg #(
        .AW(14)
    ) u_avg (
        .clk(pclk),
        .rst_n(presetn),
        .bus(avg_bus.averager)
    );

    // field views of the control registers
    logic prio;
    logic [1:0] rel_sel;
    logic [3:0] abs_off;
    logic [1:0] hyst_sel;
    logic [1:0] wait_sel;
    logic [1:0] hold_sel;
    logic [1:0] filt_sel;
    logic [7:0] target_db;

    assign prio = s_reg.prio_thr[PRIO_BIT];
    assign rel_sel = s_reg.prio_thr[REL_LSB +: 2];
    assign abs_off = s_reg.prio_thr[ABS_LSB +: 4];
    assign hyst_sel = s_reg.loop_cfg[HYST_LSB +: 2];
    assign wait_sel = s_reg.loop_cfg[WAIT_LSB +: 2];
    assign hold_sel = s_reg.loop_cfg[HOLD_LSB +: 2];
    assign filt_sel = s_reg.loop_cfg[FILT_LSB +: 2];
    assign target_db = TARGET_TAB[s_reg.target]; // RULE15

    // only samples outside the settling wait reach the averager
    assign avg_bus.smp_valid = sample_valid && (s_reg.loop == LOOP_TRACK); // RULE9
    assign avg_bus.smp = sample_amp;
    assign avg_bus.clear = s_reg.avg_clear;
    assign avg_bus.len_sel = filt_sel; // RULE14

    // combinational scratch
    logic wr;
    logic rd;
    logic [IRQ_W-1:0] evt;
    logic [IRQ_W-1:0] clr;
    logic analog_lock;
    logic digital_lock;
    logic too_high;
    logic too_low;
    logic changed;
    logic [8:0] rssi_sum;
    logic [8:0] rel_lim;
    logic signed [9:0] abs_thr;
    logic [7:0] rssi_new;
    logic abs_en;
    logic rel_en;

    // ======================================================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        s_next.avg_clear = 1'b0;
        evt = '0;
        clr = '0;
        changed = 1'b0;
        wr = psel && penable && !s_reg.pready && pwrite;
        rd = psel && penable && !s_reg.pready && !pwrite;
        abs_en = (abs_off != ABS_OFF); // RULE6
        rel_en = (rel_sel != 2'h0); // RULE3
        rssi_sum = {1'b0, avg_bus.avg}
                   + {1'b0, gain_loss(s_reg.lna1, s_reg.lna2, s_reg.dvga)};
        // referred back to full gain by adding the dB that the gain stages have cut
        rssi_new = rssi_sum[8] ? 8'hFF : rssi_sum[7:0]; // RULE7
        abs_thr = $signed({2'b00, target_db})
                  + $signed({{6{abs_off[3]}}, abs_off}); // RULE5
        rel_lim = {1'b0, s_reg.rel_base} + {1'b0, REL_TAB[rel_sel]}; // RULE4
        too_high = {1'b0, avg_bus.avg}
                   > {1'b0, target_db} + {1'b0, HYST_DN_TAB[hyst_sel]}; // RULE8
        too_low = {1'b0, avg_bus.avg} + {1'b0, HYST_UP_TAB[hyst_sel]}
                  < {1'b0, target_db}; // RULE8
        analog_lock = (hold_sel == HOLD_ANALOG) // RULE12
                      || (hold_sel == HOLD_ALL) // RULE13
                      || ((hold_sel == HOLD_SYNC) && s_reg.sync_hold); // RULE11
        digital_lock = (hold_sel == HOLD_ALL) // RULE13
                       || ((hold_sel == HOLD_SYNC) && s_reg.sync_hold); // RULE11

        // ------------------------------------------------------------ APB
        // one wait state: the access phase ends on its second cycle
        if (psel && penable && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.prdata = '0;
            s_next.pslverr = !(hit(paddr, IDX_PRIO_THR) || hit(paddr, IDX_LOOP)
                               || hit(paddr, IDX_TARGET)
                               || hit(paddr, IDX_STATUS)
                               || hit(paddr, IDX_MASK)
                               || hit(paddr, IDX_GAIN));
        end
        if (wr) begin
            if (hit(paddr, IDX_PRIO_THR)) begin
                s_next.prio_thr = pwdata[7:0] & PRIO_THR_WMASK;
            end
            if (hit(paddr, IDX_LOOP)) begin
                s_next.loop_cfg = pwdata[7:0];
            end
            if (hit(paddr, IDX_TARGET)) begin
                s_next.target = pwdata[2:0];
            end
            if (hit(paddr, IDX_STATUS)) begin
                clr = pwdata[IRQ_W-1:0];
            end
            if (hit(paddr, IDX_MASK)) begin
                s_next.mask = pwdata[IRQ_W-1:0];
            end
            // manual gain only takes when everything is held
            if (hit(paddr, IDX_GAIN) && hold_sel == HOLD_ALL) begin // RULE13
                s_next.lna1 = pwdata[G_LNA1_LSB +: 3];
                s_next.lna2 = pwdata[G_LNA2_LSB +: 3];
                s_next.dvga = pwdata[G_DVGA_LSB +: 2];
            end
        end
        if (rd) begin
            if (hit(paddr, IDX_PRIO_THR)) begin
                s_next.prdata = {24'h000000, s_reg.prio_thr};
            end
            if (hit(paddr, IDX_LOOP)) begin
                s_next.prdata = {24'h000000, s_reg.loop_cfg};
            end
            if (hit(paddr, IDX_TARGET)) begin
                s_next.prdata = {29'h00000000, s_reg.target};
            end
            if (hit(paddr, IDX_STATUS)) begin
                s_next.prdata = 32'(s_reg.status);
            end
            if (hit(paddr, IDX_MASK)) begin
                s_next.prdata = 32'(s_reg.mask);
            end
            if (hit(paddr, IDX_GAIN)) begin
                s_next.prdata[G_LNA1_LSB +: 3] = s_reg.lna1;
                s_next.prdata[G_LNA2_LSB +: 3] = s_reg.lna2;
                s_next.prdata[G_DVGA_LSB +: 2] = s_reg.dvga;
                s_next.prdata[G_CS_BIT] = s_reg.cs;
                s_next.prdata[G_SYNC_BIT] = s_reg.sync_hold;
                s_next.prdata[G_SETTLE_BIT] = (s_reg.loop == LOOP_SETTLE);
                s_next.prdata[G_RSSI_LSB +: 8] = s_reg.rssi;
            end
        end

        // ------------------------------------------------------ sync hold
        // set wins over the restart so a sync word in that cycle still holds
        if (rx_restart) begin
            s_next.sync_hold = 1'b0;
        end
        if (sync_found && hold_sel == HOLD_SYNC) begin // RULE11
            s_next.sync_hold = 1'b1;
            evt[EV_FROZEN] = !s_reg.sync_hold;
        end

        // ------------------------------------------------------ OOK slicer
        if (sample_valid) begin
            s_next.ook = ({1'b0, sample_amp} + {1'b0, OOK_TAB[filt_sel]})
                         >= {1'b0, s_reg.rssi}; // RULE14
        end

        // ---------------------------------------------------------- loop
        case (s_reg.loop)
            LOOP_SETTLE: begin
                if (sample_valid) begin
                    if (s_reg.settle_cnt == 6'h00) begin
                        s_next.loop = LOOP_TRACK; // RULE9
                    end else begin
                        s_next.settle_cnt = s_reg.settle_cnt - 6'h01;
                    end
                end
            end
            LOOP_TRACK: begin
                if (avg_bus.avg_valid) begin
                    s_next.rssi = rssi_new;
                    // level sense, referred to the target amplitude
                    s_next.abs_hit = abs_en
                        && ($signed({2'b00, rssi_new}) >= abs_thr); // RULE6
                    // relative sense: baseline follows until a jump is seen
                    if (!rel_en) begin
                        s_next.rel_hit = 1'b0; // RULE3
                        s_next.rel_base = rssi_new;
                    end else if (!s_reg.rel_hit) begin
                        if ({1'b0, rssi_new} >= rel_lim) begin
                            s_next.rel_hit = 1'b1; // RULE4
                        end else begin
                            s_next.rel_base = rssi_new;
                        end
                    end else if ({1'b0, rssi_new} < rel_lim) begin
                        s_next.rel_hit = 1'b0;
                    end
                    // gain decision, held in hold modes
                    if (too_high) begin
                        if (!analog_lock && prio && s_reg.lna1 != 3'h0) begin
                            s_next.lna1 = s_reg.lna1 - 3'h1; // RULE1
                            changed = 1'b1;
                        end else if (!analog_lock && s_reg.lna2 != 3'h0) begin
                            s_next.lna2 = s_reg.lna2 - 3'h1; // RULE2
                            changed = 1'b1;
                        end else if (!analog_lock && s_reg.lna1 != 3'h0) begin
                            s_next.lna1 = s_reg.lna1 - 3'h1; // RULE2
                            changed = 1'b1;
                        end else if (!digital_lock
                                     && s_reg.dvga != 2'h0) begin
                            s_next.dvga = s_reg.dvga - 2'h1; // RULE12
                            changed = 1'b1;
                        end
                    end else if (too_low) begin
                        // raise in the reverse order of lowering
                        if (!digital_lock && s_reg.dvga != DVGA_MAX) begin
                            s_next.dvga = s_reg.dvga + 2'h1; // RULE10
                            changed = 1'b1;
                        end else if (!analog_lock && !prio
                                     && s_reg.lna1 != LNA_MAX) begin
                            s_next.lna1 = s_reg.lna1 + 3'h1; // RULE10
                            changed = 1'b1;
                        end else if (!analog_lock
                                     && s_reg.lna2 != LNA_MAX) begin
                            s_next.lna2 = s_reg.lna2 + 3'h1; // RULE10
                            changed = 1'b1;
                        end else if (!analog_lock
                                     && s_reg.lna1 != LNA_MAX) begin
                            s_next.lna1 = s_reg.lna1 + 3'h1; // RULE10
                            changed = 1'b1;
                        end
                    end
                    if (changed) begin
                        s_next.loop = LOOP_SETTLE;
                        s_next.settle_cnt = WAIT_TAB[wait_sel] - 6'h01; // RULE9
                        s_next.avg_clear = 1'b1;
                        evt[EV_GAIN] = 1'b1;
                    end
                end
            end
            default: begin
                s_next.loop = LOOP_TRACK;
            end
        endcase

        // ------------------------------------------------- carrier sense
        // a field switched off takes effect at once, not at the next average
        s_next.cs = (s_next.abs_hit && abs_en)
                    || (s_next.rel_hit && rel_en); // RULE16
        evt[EV_CS_RISE] = s_next.cs && !s_reg.cs;
        evt[EV_CS_FALL] = !s_next.cs && s_reg.cs;

        // ------------------------------------------------------ interrupt
        // a new event beats a write-one-to-clear in the same cycle
        s_next.status = (s_reg.status & ~clr) | evt;
        s_next.irq = |(s_next.status & s_next.mask);
    end

    // ======================================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.prio_thr <= PRIO_THR_RST;
            s_reg.loop_cfg <= LOOP_RST;
            s_reg.target <= TARGET_RST;
            s_reg.lna1 <= LNA_MAX;
            s_reg.lna2 <= LNA_MAX;
            s_reg.dvga <= DVGA_MAX;
            s_reg.loop <= LOOP_TRACK;
        end else begin
            s_reg <= s_next;
        end
    end

    // ======================================================================
    // outputs
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign lna1_gain = s_reg.lna1;
    assign lna2_gain = s_reg.lna2;
    assign dvga_gain = s_reg.dvga;
    assign carrier_sense = s_reg.cs;
    assign ook_bit = s_reg.ook;
    assign rssi_db = s_reg.rssi;
    assign irq = s_reg.irq;

endmodule : gcs_top

`default_nettype wire

// File: pkg/gcs_pkg.sv
// gcs_pkg: constants and types for the gain control and carrier sense block
// ==========================================================================
// Summary of operation
// RULE1: with the stage order bit at 1 the first amplifier stage is cut first.
// RULE2: with the stage order bit at 0 the second stage goes to minimum first.
// RULE3: a relative step code of 00, the reset value, turns relative sense off.
// RULE4: relative step codes 01, 10, 11 assert sense on a 6, 10 or 14 dB rise.
// RULE5: the level offset is a signed 4-bit dB offset from the target.
// RULE6: level offset 1000 turns level sense off; others span -7 to +7 dB.
// RULE7: the level is compared as amplitude referred back to full gain.
// RULE8: the hysteresis field, reset 10, picks a wider asymmetric dead zone.
// RULE9: after a gain step 8, 16, 24 or 32 samples are skipped, reset 01.
// RULE10: hold select 00, the reset value, adjusts gain whenever needed.
// RULE11: hold select 01 stops gain changes once a sync word is seen.
// RULE12: hold select 10 holds analog gain while digital gain still adapts.
// RULE13: hold select 11 holds all gain and lets software set it by hand.
// RULE14: averaging over 8 to 64 samples pairs with a 4 to 16 dB OOK margin.
// RULE15: target codes 0 to 7 mean 24,27,30,33,36,38,40,42 dB, reset 3.
// RULE16: with both sense thresholds off carrier sense stays low.
`default_nettype none

package gcs_pkg;

    // ======================================================================
    // register map (indices; byte address is four times the index)
    localparam logic [7:0] IDX_PRIO_THR = 8'h1C;
    localparam logic [7:0] IDX_LOOP = 8'h1D;
    localparam logic [7:0] IDX_TARGET = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;
    localparam logic [7:0] IDX_MASK = 8'h42;
    localparam logic [7:0] IDX_GAIN = 8'h43;

    // ======================================================================
    // field positions
    localparam int PRIO_BIT = 6;
    localparam int REL_LSB = 4;
    localparam int ABS_LSB = 0;
    localparam int HYST_LSB = 6;
    localparam int WAIT_LSB = 4;
    localparam int HOLD_LSB = 2;
    localparam int FILT_LSB = 0;
    localparam int G_DVGA_LSB = 0;
    localparam int G_LNA2_LSB = 2;
    localparam int G_LNA1_LSB = 5;
    localparam int G_CS_BIT = 8;
    localparam int G_SYNC_BIT = 9;
    localparam int G_SETTLE_BIT = 10;
    localparam int G_RSSI_LSB = 16;

    // ======================================================================
    // reset values and codes
    localparam logic [7:0] PRIO_THR_RST = 8'h40;
    localparam logic [7:0] PRIO_THR_WMASK = 8'h7F;
    localparam logic [7:0] LOOP_RST = 8'h91;
    localparam logic [2:0] TARGET_RST = 3'h3;
    localparam logic [3:0] ABS_OFF = 4'h8;
    localparam logic [1:0] HOLD_NONE = 2'h0;
    localparam logic [1:0] HOLD_SYNC = 2'h1;
    localparam logic [1:0] HOLD_ANALOG = 2'h2;
    localparam logic [1:0] HOLD_ALL = 2'h3;

    // ======================================================================
    // lookup tables, indexed by field code
    localparam logic [3:0][5:0] WAIT_TAB = {6'h20, 6'h18, 6'h10, 6'h08};
    localparam logic [3:0][7:0] REL_TAB = {8'h0E, 8'h0A, 8'h06, 8'h00};
    localparam logic [3:0][7:0] OOK_TAB = {8'h10, 8'h0C, 8'h08, 8'h04};
    localparam logic [3:0][7:0] HYST_DN_TAB = {8'h06, 8'h04, 8'h03, 8'h02};
    localparam logic [3:0][7:0] HYST_UP_TAB = {8'h08, 8'h06, 8'h04, 8'h02};
    localparam logic [7:0][7:0] TARGET_TAB = {8'h2A, 8'h28, 8'h26, 8'h24,
                                              8'h21, 8'h1E, 8'h1B, 8'h18};
    localparam int AVG_MIN_SHIFT = 3;

    // ======================================================================
    // gain stages
    localparam logic [2:0] LNA_MAX = 3'h7;
    localparam logic [1:0] DVGA_MAX = 2'h3;
    localparam logic [7:0] LNA_STEP_DB = 8'h03;
    localparam logic [7:0] DVGA_STEP_DB = 8'h06;

    // ======================================================================
    // interrupt status bits
    localparam int IRQ_W = 4;
    localparam int EV_GAIN = 0;
    localparam int EV_CS_RISE = 1;
    localparam int EV_CS_FALL = 2;
    localparam int EV_FROZEN = 3;

    typedef enum logic {LOOP_TRACK, LOOP_SETTLE} gcs_loop_t;

endpackage : gcs_pkg

`default_nettype wire

// File: pkg/gcs_avg_if.sv
// gcs_avg_if: sample stream and averaged amplitude between loop and averager
`default_nettype none

interface gcs_avg_if;
    logic smp_valid;
    logic [7:0] smp;
    logic clear;
    logic [1:0] len_sel;
    logic avg_valid;
    logic [7:0] avg;

    modport producer (
        output smp_valid, smp, clear, len_sel,
        input avg_valid, avg
    );
    modport averager (
        input smp_valid, smp, clear, len_sel,
        output avg_valid, avg
    );
endinterface : gcs_avg_if

`default_nettype wire

// File: verilog/gcs_avg.sv
// gcs_avg: block averager of channel filter amplitude over 8 to 64 samples
`default_nettype none

module gcs_avg
    import gcs_pkg::*;
#(
    parameter int AW = 14
) (
    input wire logic clk,
    input wire logic rst_n,
    gcs_avg_if.averager bus
);

    typedef struct packed {
        logic [AW-1:0] acc;
        logic [6:0] cnt;
        logic [7:0] avg;
        logic vld;
    } gcs_avg_state_t;

    gcs_avg_state_t s_reg;
    gcs_avg_state_t s_next;
    logic [AW-1:0] sum;
    logic [AW-1:0] shifted;
    logic [6:0] len;

    always_comb begin
        s_next = s_reg;
        s_next.vld = 1'b0;
        len = 7'h08 << bus.len_sel; // RULE14
        sum = s_reg.acc + AW'(bus.smp);
        shifted = sum >> (AVG_MIN_SHIFT + int'(bus.len_sel));
        if (bus.clear) begin
            s_next.acc = '0;
            s_next.cnt = '0;
        end else if (bus.smp_valid) begin
            if (s_reg.cnt + 7'h01 == len) begin
                s_next.avg = shifted[7:0];
                s_next.vld = 1'b1;
                s_next.acc = '0;
                s_next.cnt = '0;
            end else begin
                s_next.acc = sum;
                s_next.cnt = s_reg.cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.avg_valid = s_reg.vld;
    assign bus.avg = s_reg.avg;

endmodule : gcs_avg

`default_nettype wire

// File: sim/gcs_top_monitor.sv
// gcs_top_monitor: assertions on the ports of gcs_top
`default_nettype none
module gcs_top_monitor
    import gcs_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic pclk, presetn, psel, penable, pwrite, pready,
    input wire logic pslverr, sample_valid, carrier_sense, ook_bit,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0] lna1_gain, lna2_gain,
    input wire logic [1:0] dvga_gain
);
    // ========
    // config shadow; q holds checks off until a write has settled
    logic wr, q;
    logic [7:0] pt_reg, lp_reg;
    logic [2:0] age_reg;
    assign wr = psel && penable && pready && pwrite && !pslverr;
    assign q = age_reg > 3'h4 && !wr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pt_reg <= PRIO_THR_RST;
            lp_reg <= LOOP_RST;
            age_reg <= 3'h0;
        end else begin
            if (wr && paddr == AW'({IDX_PRIO_THR, 2'h0})) begin
                pt_reg <= pwdata[7:0];
            end
            if (wr && paddr == AW'({IDX_LOOP, 2'h0})) begin
                lp_reg <= pwdata[7:0];
            end
            age_reg <= wr ? 3'h0 : age_reg + 3'(age_reg != 3'h7);
        end
    end
    // ========
    // assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_next:
        assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("pready long");
    a_err_ready:
        assert property (pslverr |-> pready) else $error("lone pslverr");
    a_first_stage:
        assert property (q && pt_reg[6] && lna2_gain < $past(lna2_gain)
        |-> lna1_gain == 3'h0) else $error("stage two cut early");
    a_second_stage:
        assert property (q && !pt_reg[6] && lna1_gain < $past(lna1_gain)
        |-> lna2_gain == 3'h0) else $error("stage one cut early");
    a_analog_held:
        assert property (q && lp_reg[3:2] == HOLD_ANALOG
        |=> $stable(lna1_gain) && $stable(lna2_gain))
        else $error("analog gain moved");
    a_all_held:
        assert property (q && lp_reg[3:2] == HOLD_ALL
        |=> $stable({lna1_gain, lna2_gain, dvga_gain}))
        else $error("gain moved");
    a_sense_off:
        assert property (q && pt_reg[5:0] == {2'h0, ABS_OFF}
        |-> !carrier_sense) else $error("sense while off");
    a_ook_sample:
        assert property (!$past(sample_valid) |-> $stable(ook_bit))
        else $error("ook moved");
    c_cut: cover property (lna1_gain < $past(lna1_gain));
    c_sense: cover property ($rose(carrier_sense));
    c_err: cover property (pslverr);
endmodule : gcs_top_monitor
bind gcs_top gcs_top_monitor #(.AW(AW)) mon_u (.*);
`default_nettype wire

// File: sim/tb.sv
// tb: self-checking bench for gcs_top
`default_nettype none
module tb import gcs_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic sample_valid, sync_found, rx_restart, carrier_sense, ook_bit, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] sample_amp, rssi_db, amp, g;
    logic [2:0] lna1_gain, lna2_gain;
    logic [1:0] dvga_gain;
    wire [7:0] gn = {lna1_gain, lna2_gain, dvga_gain};
    int error_cnt = 0;
    int checked = 0;
    int off, tgt;
    int tdb [8] = '{24, 27, 30, 33, 36, 38, 40, 42};
    logic [7:0] rix [5] = '{IDX_PRIO_THR, IDX_LOOP, IDX_TARGET, 8'h41, 8'h42};
    logic [7:0] rexp [5] = '{8'h40, 8'h91, 8'h03, 8'h00, 8'h00};

    gcs_top #(.AW(12)) dut_u (.*);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ========
    // tasks
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic rst();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : rst
    // waits on pready, never on a fixed latency
    task automatic apb(input logic w, input logic [7:0] i,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
        if (n >= 40) begin
            error_cnt++;
            summarize();
        end
    endtask : apb
    task automatic feed(input int n, input logic [7:0] a);
        repeat (n) begin
            sample_valid <= 1'b1;
            sample_amp <= a;
            @(posedge pclk);
        end
        sample_valid <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : feed
    function automatic logic exp_cs(input int a, input int t, input int o);
        return o != 8 && a >= tdb[t] + ((o > 7) ? o - 16 : o);
    endfunction : exp_cs
    // ========
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, sample_valid} = '0;
        {sync_found, rx_restart, paddr, pwdata, sample_amp} = '0;
        void'($urandom(32'hCD58));
        rst();
        for (int i = 0; i < 5; i++) begin
            apb(0, rix[i], 0);
            check(rd, 32'(rexp[i]));
        end
        apb(1, IDX_PRIO_THR, 32'hFF);
        apb(0, IDX_PRIO_THR, 0);
        check(rd, 32'h7F);
        apb(0, 8'h20, 0);
        check(rd, 0);
        check(err, 1);
        for (int i = 0; i < 8; i++) begin
            rst();
            off = i == 0 ? 8 : i == 1 ? 9 : i == 2 ? 7 : $urandom_range(15);
            tgt = $urandom_range(7);
            amp = 8'(tdb[tgt] + int'($urandom_range(10)) - 7);
            apb(1, IDX_TARGET, 32'(tgt));
            apb(1, IDX_PRIO_THR, 32'h40 | 32'(off));
            feed(16, amp);
            check(rssi_db, amp);
            check(carrier_sense, exp_cs(amp, tgt, off));
            check(ook_bit, 1);
        end
        for (int p = 0; p < 2; p++) begin
            rst();
            apb(1, IDX_PRIO_THR, 32'h08 | 32'(p << 6));
            feed(16, 8'($urandom_range(70, 60)));
            check(p ? lna2_gain : lna1_gain, 7);
            check((p ? lna1_gain : lna2_gain) < 3'h7, 1);
            check(carrier_sense, 0);
            apb(0, 8'h41, 0);
            check(rd, 1);
            check(irq, 0);
            apb(1, 8'h42, 1);
            check(irq, 1);
            apb(1, 8'h41, 1);
            check(irq, 0);
        end
        rst();
        g = 8'($urandom_range(255, 128));
        apb(1, IDX_LOOP, 32'h9D);
        apb(1, 8'h43, 32'(g));
        check(gn, g);
        feed(40, 8'h46);
        check(gn, g);
        apb(1, IDX_LOOP, 32'h99);
        feed(40, 8'h46);
        check(gn[7:2], g[7:2]);
        apb(1, IDX_LOOP, 32'h9D);
        apb(1, 8'h43, 32'(g));
        apb(1, IDX_LOOP, 32'h95);
        sync_found <= 1'b1;
        @(posedge pclk);
        sync_found <= 1'b0;
        feed(80, 8'h46);
        check(gn, g);
        rx_restart <= 1'b1;
        @(posedge pclk);
        rx_restart <= 1'b0;
        feed(80, 8'h46);
        check(lna1_gain < g[7:5], 1);
        summarize();
    end
endmodule : tb
`default_nettype wire
